/* hw/ofc_top.v */
`timescale 1ns/1ps
`include "ofc_consts.vh"
//
// Functional notes
// R1: Erase one whole 1 kB unit
// R2: Erased unit reads all ones
// R3: Protection held per 2 kB region
// R4: Read-only refuses erase and program
// R5: Execute-only serves instruction fetches only
// R6: Program one word, clear bits only
// R7: Pulse durations counted in clock cycles
// R8: Host loads cycles per microsecond first
// R9: Violation sets access-violation source
// R10: Completion sets operation-complete source
// R11: Protection effective immediately, commit separate
// R12: Write-one clear deasserts sticky source
// R13: Per-source enable gates interrupt line
// R14: Raw and masked status both readable
// R15: Host gives word-aligned addresses
// R16: Protection only tightens, never loosens
// R17: Uncommitted protection reverts on reset
// R18: Busy shown during erase or program
module ofc_top #(
  parameter AW = 14,
  parameter REGIONS = 8
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // Register port
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  // Array read port (processor, debugger, fetch)
  input wire i_rd_req,
  input wire i_rd_fetch,
  input wire [AW-1:0] i_rd_addr,
  output reg [31:0] o_rd_data,
  output reg o_rd_err,
  // Interrupt
  output wire o_irq
);
  localparam WORDS = 1 << (AW - 2);
  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_PROG = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam ST_DONE = 2'h3;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Array words; never reset, like the cells they stand for
  reg [31:0] mem_r [0:WORDS-1];
  // Working protection level of every region, two bits each
  wire [2*REGIONS-1:0] prot_w;
  // Operation target, cycles per microsecond, interrupt status and mask
  reg [AW-1:0] addr_r;
  reg [31:0] data_r;
  reg [7:0] usec_r;
  reg [1:0] ris_r;
  reg [1:0] im_r;
  // Sequencer and erase walk
  reg [1:0] state_r;
  reg [7:0] ecnt_r;
  reg tstart_r;
  // Timer handshake
  wire t_active;
  wire t_done;
  genvar g;

  // Region index of a byte address, one per 2 kB
  function [2:0] region_of;
    input [AW-1:0] a;
    begin
      region_of = a[13:11]; // R3
    end
  endfunction

  // Write allowed only for read-write regions
  function writable;
    input [1:0] p;
    begin
      writable = (p == `OFC_PROT_RW); // R4 R5
    end
  endfunction

  // Level of one region out of the packed per-region levels
  function [1:0] level_of;
    input [2*REGIONS-1:0] v;
    input [2:0] r;
    begin
      level_of = v[2*r +: 2]; // R3
    end
  endfunction

  // Register write decodes, one per target
  wire wr_addr = i_reg_wr && (i_reg_addr == `OFC_REG_ADDR);
  wire wr_data = i_reg_wr && (i_reg_addr == `OFC_REG_DATA);
  wire wr_usec = i_reg_wr && (i_reg_addr == `OFC_REG_USEC);
  wire wr_im = i_reg_wr && (i_reg_addr == `OFC_REG_IM);
  wire wr_ris = i_reg_wr && (i_reg_addr == `OFC_REG_RIS);
  wire wr_prot = i_reg_wr && (i_reg_addr == `OFC_REG_PROT);
  wire wr_commit = i_reg_wr && (i_reg_addr == `OFC_REG_COMMIT);
  // Write-one-to-clear requests
  wire clr_done = wr_ris && i_reg_wdata[`OFC_INT_DONE];
  wire clr_viol = wr_ris && i_reg_wdata[`OFC_INT_VIOL];

  // Protection of the current target
  wire [1:0] cur_prot = level_of(prot_w, region_of(addr_r));
  wire wr_ctrl = i_reg_wr && (i_reg_addr == `OFC_REG_CTRL);
  wire cmd_prog = wr_ctrl && i_reg_wdata[`OFC_CTRL_PROG];
  wire cmd_erase = wr_ctrl && i_reg_wdata[`OFC_CTRL_ERASE] && !i_reg_wdata[`OFC_CTRL_PROG];
  // Busy covers the completion cycle too
  wire busy = (state_r != ST_IDLE); // R18
  // Violations: refused command or blocked data read
  wire cmd_bad = (cmd_prog || cmd_erase) && !busy && !writable(cur_prot);
  wire rd_bad = i_rd_req && !i_rd_fetch && (level_of(prot_w, region_of(i_rd_addr)) == `OFC_PROT_XO);
  wire viol_evt = cmd_bad || rd_bad; // R9
  wire done_evt = (state_r == ST_DONE); // R10

  // ----------------------------------------
  // Pulse timer
  // ----------------------------------------
  // One timer serves both operations; they never overlap
  ofc_pulse_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_start(tstart_r),
    .i_clk_per_us(usec_r),
    .i_us(state_r == ST_ERASE ? `OFC_ERASE_US : `OFC_PROG_US),
    .o_active(t_active),
    .o_done(t_done)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Array contents are not reset: flash keeps data across reset
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      tstart_r <= 1'b0;
      ecnt_r <= 8'h00;
    end else begin
      tstart_r <= 1'b0;
      case (state_r)
        // Commands are taken only when idle; one sent while busy is dropped
        ST_IDLE: begin
          if (cmd_prog && writable(cur_prot)) begin
            state_r <= ST_PROG;
            tstart_r <= 1'b1;
          end else if (cmd_erase && writable(cur_prot)) begin
            state_r <= ST_ERASE;
            tstart_r <= 1'b1;
            ecnt_r <= 8'h00;
          end
        end
        ST_PROG: begin
          if (t_done) begin
            // Bits only go from one to zero
            mem_r[addr_r[AW-1:2]] <= mem_r[addr_r[AW-1:2]] & data_r; // R6
            state_r <= ST_DONE;
          end
        end
        ST_ERASE: begin
          // Erase one word to all ones per cycle while the pulse runs; pulse outlasts 256 cycles
          if (ecnt_r != 8'hFF || t_active) begin
            mem_r[{addr_r[AW-1:10], ecnt_r}] <= 32'hFFFFFFFF; // R1 R2
            if (ecnt_r != 8'hFF) begin
              ecnt_r <= ecnt_r + 8'h01;
            end
          end
          if (t_done) begin
            state_r <= ST_DONE;
          end
        end
        // Completion cycle: busy still high, then back to idle
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Protection
  // ----------------------------------------
  // One slice per 2 kB region; each keeps a working and a committed level
  generate
    for (g = 0; g < REGIONS; g = g + 1) begin : g_region
      localparam [2:0] IDX = g;
      // Committed copy has no reset: a commit must outlive every reset
      reg [1:0] saved_r = `OFC_SAVED_PROT;
      reg [1:0] lvl_r;
      wire [1:0] want = i_reg_wdata[9:8];
      wire hit = wr_prot && (i_reg_wdata[2:0] == IDX);
      // Level 3 is no encoding and never loads
      wire tighter = (lvl_r == `OFC_PROT_RW && want != 2'h3) ||
        (lvl_r == `OFC_PROT_RO && want == `OFC_PROT_XO); // R16
      wire commit = wr_commit && i_reg_wdata[0];

      assign prot_w[2*g +: 2] = lvl_r;

      // Working level reloads the committed level on reset
      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          lvl_r <= saved_r; // R17
        end else if (hit && tighter) begin
          // Takes effect at once, without a commit
          lvl_r <= want; // R11 R16
        end
      end

      // Commit copies the working level and cannot be loosened later
      always @(posedge i_ref_clk) begin
        if (!i_srst && commit) begin
          saved_r <= lvl_r; // R11
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Address and data freeze while an operation runs, so the target cannot move
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_r <= {AW{1'b0}};
      data_r <= 32'hFFFFFFFF;
      usec_r <= `OFC_USEC_RST;
      im_r <= 2'h0;
    end else begin
      if (wr_addr && !busy) begin
        addr_r <= {i_reg_wdata[AW-1:2], 2'h0}; // R15
      end
      if (wr_data && !busy) begin
        data_r <= i_reg_wdata;
      end
      // Rate may change mid-operation; the running pulse then follows it
      if (wr_usec) begin
        usec_r <= i_reg_wdata[7:0]; // R8
      end
      if (wr_im) begin
        im_r <= i_reg_wdata[1:0]; // R13
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Sticky sources; a set wins over a clear in the same cycle so no event is lost
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      ris_r <= 2'h0;
    end else begin
      ris_r[`OFC_INT_DONE] <= done_evt || (ris_r[`OFC_INT_DONE] && !clr_done); // R10 R12
      ris_r[`OFC_INT_VIOL] <= viol_evt || (ris_r[`OFC_INT_VIOL] && !clr_viol); // R9 R12
    end
  end

  // Level output: only enabled sources reach the processor
  assign o_irq = |(ris_r & im_r); // R13

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  // Register read data, one cycle after strobe
  // Idle cycles and unmapped addresses read as zero
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `OFC_REG_ADDR: o_reg_rdata <= {{(32-AW){1'b0}}, addr_r};
        `OFC_REG_DATA: o_reg_rdata <= data_r;
        `OFC_REG_USEC: o_reg_rdata <= {24'h000000, usec_r};
        `OFC_REG_RIS: o_reg_rdata <= {30'h00000000, ris_r}; // R14
        `OFC_REG_IM: o_reg_rdata <= {30'h00000000, im_r};
        `OFC_REG_MIS: o_reg_rdata <= {30'h00000000, ris_r & im_r}; // R14
        `OFC_REG_STAT: o_reg_rdata <= {31'h00000000, busy}; // R18
        `OFC_REG_PROT: o_reg_rdata <= {30'h00000000, level_of(prot_w, i_reg_wdata[2:0])}; // R3
        default: o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

  // Array read: blocked data reads return zero and flag an error
  // Fetches are always served; only data reads meet execute-only
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rd_data <= 32'h00000000;
      o_rd_err <= 1'b0;
    end else begin
      o_rd_err <= rd_bad; // R5
      o_rd_data <= (i_rd_req && !rd_bad) ? mem_r[i_rd_addr[AW-1:2]] : 32'h00000000; // R4 R5
    end
  end
endmodule

/* hw/ofc_consts.vh */
`ifndef OFC_CONSTS_VH
`define OFC_CONSTS_VH
// Register offsets (byte addresses, one word each)
`define OFC_REG_CTRL      8'h00
`define OFC_REG_ADDR      8'h04
`define OFC_REG_DATA      8'h08
`define OFC_REG_USEC      8'h0C
`define OFC_REG_RIS       8'h10
`define OFC_REG_IM        8'h14
`define OFC_REG_MIS       8'h18
`define OFC_REG_STAT      8'h1C
`define OFC_REG_PROT      8'h20
`define OFC_REG_COMMIT    8'h24
`define OFC_REG_FETCH     8'h28
// Control command bit positions
`define OFC_CTRL_PROG     0
`define OFC_CTRL_ERASE    1
// Interrupt bit positions
`define OFC_INT_DONE      0
`define OFC_INT_VIOL      1
// Protection encodings
`define OFC_PROT_RW       2'h0
`define OFC_PROT_RO       2'h1
`define OFC_PROT_XO       2'h2
// Reset values
`define OFC_USEC_RST      8'h00
`define OFC_SAVED_PROT    2'h0
// Pulse times in microseconds
`define OFC_PROG_US       16'h0014
`define OFC_ERASE_US      16'h2EE0
`endif

/* hw/ofc_pulse_timer.v */
`timescale 1ns/1ps
module ofc_pulse_timer (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // Control
  input wire i_start,
  input wire [7:0] i_clk_per_us,
  input wire [15:0] i_us,
  // Status
  output wire o_active,
  output reg o_done
);
  reg [7:0] cyc_r;
  reg [15:0] us_r;
  reg act_r;

  assign o_active = act_r;

  // Counts microseconds from cycles-per-microsecond
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      cyc_r <= 8'h00;
      us_r <= 16'h0000;
      act_r <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !act_r) begin
        act_r <= 1'b1;
        cyc_r <= 8'h00;
        us_r <= 16'h0000;
      end else if (act_r) begin
        // A zero rate still ticks every cycle so the pulse ends
        if (cyc_r + 8'h01 >= i_clk_per_us) begin // R7
          cyc_r <= 8'h00;
          if (us_r + 16'h0001 >= i_us) begin
            act_r <= 1'b0;
            o_done <= 1'b1;
          end else begin
            us_r <= us_r + 16'h0001;
          end
        end else begin
          cyc_r <= cyc_r + 8'h01;
        end
      end
    end
  end
endmodule

/* testbench/ofc_monitor.sv */
`timescale 1ns/1ps
module ofc_monitor #(
  parameter AW = 14
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // Register port
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [31:0] o_reg_rdata,
  // Array read port and interrupt
  input wire i_rd_req,
  input wire i_rd_fetch,
  input wire [AW-1:0] i_rd_addr,
  input wire [31:0] o_rd_data,
  input wire o_rd_err,
  input wire o_irq
);
  // All checks share the one clock and its reset
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  chk_fetch_no_err: assert property (i_rd_req && i_rd_fetch |=> !o_rd_err)
    else $error("fetch flagged as blocked");
  chk_err_data_zero: assert property (o_rd_err |-> o_rd_data == 32'h0)
    else $error("blocked read leaked data");
  chk_err_cause: assert property (o_rd_err |-> $past(i_rd_req && !i_rd_fetch))
    else $error("error without data read");
  chk_rd_idle: assert property (!$past(i_rd_req) |-> o_rd_data == 32'h0)
    else $error("array data without request");
  chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("register data without read");
  chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr > 8'h28 |=> o_reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_off_irq: assert property (i_reg_wr && i_reg_addr == 8'h14 && i_reg_wdata[1:0] == 2'h0
    |=> !o_irq ##1 (!o_irq || $past(i_reg_wr && i_reg_addr == 8'h14)))
    else $error("irq with all sources disabled");
  chk_mis_irq: assert property (i_reg_rd && i_reg_addr == 8'h18
    |=> (o_reg_rdata[1:0] != 2'h0) == $past(o_irq))
    else $error("masked status disagrees with irq");
endmodule

/* testbench/ofc_host_model.sv */
`timescale 1ns/1ps
// Processor side: one-cycle register strobes and array reads
module ofc_host_model #(
  parameter AW = 14
) (
  // Clock
  input wire i_ref_clk,
  // Register port
  output logic [7:0] o_reg_addr = 8'h0,
  output logic [31:0] o_reg_wdata = 32'h0,
  output logic o_reg_wr = 1'b0,
  output logic o_reg_rd = 1'b0,
  // Array read port
  output logic o_rd_req = 1'b0,
  output logic o_rd_fetch = 1'b0,
  output logic [AW-1:0] o_rd_addr = '0
);
  // One write or read; the #1 lets the answer settle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_reg_wr <= w;
    o_reg_rd <= !w;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    #1;
  endtask
  // Data read or fetch of one word
  task automatic arr(input logic f, input logic [AW-1:0] a);
    @(posedge i_ref_clk);
    o_rd_req <= 1'b1;
    o_rd_fetch <= f;
    o_rd_addr <= a;
    @(posedge i_ref_clk);
    o_rd_req <= 1'b0;
    #1;
  endtask
endmodule

/* testbench/onchip_flash_controller_bench.sv */
`timescale 1ns/1ps
module onchip_flash_controller_bench;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  wire [7:0] ra;
  wire [31:0] wd, o_reg_rdata, o_rd_data;
  wire wr, rdq, rq, rf, o_rd_err, o_irq;
  wire [13:0] aa;
  int failures = 0;
  int num_checks = 0;
  int n;
  always #4 i_ref_clk = ~i_ref_clk;
  ofc_host_model h (.i_ref_clk(i_ref_clk), .o_reg_addr(ra), .o_reg_wdata(wd), .o_reg_wr(wr),
    .o_reg_rd(rdq), .o_rd_req(rq), .o_rd_fetch(rf), .o_rd_addr(aa));
  ofc_top dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
    .i_reg_rd(rdq), .o_reg_rdata(o_reg_rdata), .i_rd_req(rq), .i_rd_fetch(rf), .i_rd_addr(aa),
    .o_rd_data(o_rd_data), .o_rd_err(o_rd_err), .o_irq(o_irq));
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    h.bus(1'b0, a, d);
    check(o_reg_rdata, e);
  endtask
  task automatic ard(input logic f, input logic [13:0] a, input logic [31:0] e, input logic er);
    h.arr(f, a);
    check(o_rd_data, e);
    check({31'h0, o_rd_err}, {31'h0, er});
  endtask
  // Issue a command, then poll busy; n counts the polls
  task automatic cmd(input logic [13:0] a, input logic [31:0] d, input logic [1:0] c);
    h.bus(1'b1, 8'h04, {18'h0, a});
    h.bus(1'b1, 8'h08, d);
    h.bus(1'b1, 8'h00, {30'h0, c});
    n = 0;
    do begin
      h.bus(1'b0, 8'h1C, 32'h0);
      n++;
    end while (o_reg_rdata[0] === 1'b1 && n < 9000);
    if (n >= 9000) failures++;
  endtask
  task automatic do_reset;
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    i_srst <= 1'b0;
  endtask
  // Watchdog: two erases plus margin
  initial begin
    #(8 * 60000);
    failures++;
    report_and_stop;
  end
  // -------------------
  // Main sequence
  // -------------------
  initial begin
    do_reset;
    h.bus(1'b1, 8'h0C, 32'h1);
    h.bus(1'b1, 8'h14, 32'h3);
    cmd(14'h0, 32'h0, 2'h2);
    check(n > 1, 32'h1);
    ard(1'b0, 14'h3FC, 32'hFFFFFFFF, 1'b0);
    rd(8'h10, 32'h0, 32'h1);
    check(o_irq, 32'h1);
    h.bus(1'b1, 8'h10, 32'h1);
    rd(8'h10, 32'h0, 32'h0);
    // Slower timebase must stretch the pulse
    h.bus(1'b1, 8'h0C, 32'h2);
    cmd(14'h0, 32'hFF00FF00, 2'h1);
    check(n >= 20 && n <= 24, 32'h1);
    ard(1'b0, 14'h0, 32'hFF00FF00, 1'b0);
    cmd(14'h0, 32'h0FF00FF0, 2'h1);
    ard(1'b0, 14'h0, 32'h0F000F00, 1'b0);
    cmd(14'h0, 32'hFFFFFFFF, 2'h1);
    ard(1'b0, 14'h0, 32'h0F000F00, 1'b0);
    h.bus(1'b1, 8'h0C, 32'h1);
    cmd(14'h400, 32'h0, 2'h2);
    ard(1'b0, 14'h7FC, 32'hFFFFFFFF, 1'b0);
    ard(1'b0, 14'h0, 32'h0F000F00, 1'b0);
    h.bus(1'b1, 8'h10, 32'h3);
    h.bus(1'b1, 8'h20, 32'h100);
    rd(8'h20, 32'h0, 32'h1);
    cmd(14'h0, 32'h0, 2'h1);
    check(n, 32'h1);
    cmd(14'h4, 32'h0, 2'h2);
    check(n, 32'h1);
    ard(1'b0, 14'h0, 32'h0F000F00, 1'b0);
    rd(8'h10, 32'h0, 32'h2);
    h.bus(1'b1, 8'h20, 32'h0);
    rd(8'h20, 32'h0, 32'h1);
    h.bus(1'b1, 8'h20, 32'h200);
    h.bus(1'b1, 8'h20, 32'h100);
    rd(8'h20, 32'h0, 32'h2);
    ard(1'b0, 14'h0, 32'h0, 1'b1);
    ard(1'b1, 14'h0, 32'h0F000F00, 1'b0);
    rd(8'h20, 32'h1, 32'h0);
    rd(8'h18, 32'h0, 32'h2);
    h.bus(1'b1, 8'h14, 32'h0);
    check(o_irq, 32'h0);
    rd(8'h18, 32'h0, 32'h0);
    rd(8'h10, 32'h0, 32'h2);
    h.bus(1'b1, 8'h10, 32'h2);
    rd(8'h10, 32'h0, 32'h0);
    rd(8'h30, 32'h0, 32'h0);
    do_reset;
    rd(8'h20, 32'h0, 32'h0);
    h.bus(1'b1, 8'h20, 32'h102);
    h.bus(1'b1, 8'h24, 32'h1);
    do_reset;
    rd(8'h20, 32'h2, 32'h1);
    report_and_stop;
  end
endmodule
bind ofc_top ofc_monitor #(.AW(AW)) u_mon (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_rd_req(i_rd_req), .i_rd_fetch(i_rd_fetch), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
  .o_rd_err(o_rd_err), .o_irq(o_irq));
